// *** csr_regs.v ***
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`include "csr_defs.vh"

// Function
// - Reading an indirect port returns the data memory byte its pointer addresses.
// - Writing an indirect port stores the byte at the pointer's memory address.
// - ALU flag update overrides explicit writes to zero, digit carry and carry.
// - Power-down flag bit 4: set by sleep, cleared by reset, ignores writes.
// - Timeout flag bit 3: set by watchdog timeout, cleared by reset.
// - Status bit 7 pages pointer 1 between 0XXH and 1XXH; resets to 0.
// - Status bit 6 pages pointer 0 between 0XXH and 1XXH; resets to 0.
// - Bit 2 holds nibble carry for digit add/sub, inverted for borrow.
// - Bit 1 holds carry out of the top bit, inverted for borrow.
// - Bit 0 is set on a zero result and cleared otherwise.
// - Enable bit 7 is a global gate over all individual enables.
// - Enable register 07H: bits 4..0 per source, bits 6:5 absent, reset 0.
// - Flag register 06H: bits 4..0 set by events, bits 7:5 absent, reset 0.
// - Bit 1 serves port B line 1, bit 0 serves port B line 0.
// - An accepted interrupt loads the program counter with the shared vector.
// - Indirect accesses reach general data memory 80h to 17Fh.
module csr_regs (
    // Clock and reset.
    input wire ref_clk_i,
    input wire rst_b_i,
    // Wishbone slave.
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [4:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // ALU results from the execution core.
    input wire alu_flag_upd_i,
    input wire alu_is_sub_i,
    input wire [7:0] alu_result_i,
    input wire alu_carry_i,
    input wire alu_digit_carry_i,
    // Core events.
    input wire sleep_exec_i,
    input wire wdt_timeout_i,
    input wire irq_take_i,
    // Interrupt sources.
    input wire timer_event_i,
    input wire twowire_event_i,
    input wire converter_event_i,
    input wire port_b_line_1_event_i,
    input wire port_b_line_0_event_i,
    // Core-facing results.
    output wire irq_request_o,
    output reg pc_load_o,
    output reg [11:0] pc_load_addr_o,
    output reg [7:0] status_o
);

    reg [7:0] data_mem [0:`CSR_RAM_DEPTH-1];

    reg [7:0] indirect_pointer0;
    reg [7:0] indirect_pointer1;
    reg pointer1_page_select;
    reg pointer0_page_select;
    reg power_down_flag;
    reg watchdog_timeout_flag;
    reg digit_carry_flag;
    reg carry_flag;
    reg zero_flag;
    reg [7:0] interrupt_enable_mask;
    reg [`CSR_IRQ_SRCS-1:0] irq_pending;

    wire bus_req;
    wire bus_wr;
    wire bus_rd_start;
    wire [`CSR_IDX_W-1:0] reg_idx;
    wire [7:0] wr_byte;
    wire [8:0] eff_addr0;
    wire [8:0] eff_addr1;
    wire [8:0] sel_addr;
    wire [8:0] sel_offset;
    wire sel_in_ram;
    wire ind_hit;
    wire status_wr;
    wire alu_zero;
    wire alu_carry;
    wire alu_digit_carry;
    wire [`CSR_IRQ_SRCS-1:0] irq_event;
    wire [7:0] status_byte;
    wire [7:0] pending_byte;
    reg [7:0] rd_byte;

    // Accesses complete one cycle after the request is seen, and a write
    // commits at the same edge at which the master samples ack high.
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign bus_wr = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
    assign bus_rd_start = bus_req & ~wb_we_i & ~wb_ack_o;
    assign reg_idx = wb_adr_i[4:2];
    assign wr_byte = wb_dat_i[7:0];

    assign eff_addr0 = {pointer0_page_select, indirect_pointer0};
    assign eff_addr1 = {pointer1_page_select, indirect_pointer1};
    assign sel_addr = (reg_idx == `CSR_IDX_IND1) ? eff_addr1 : eff_addr0;
    assign sel_offset = sel_addr - `CSR_RAM_BASE;
    // Addresses outside general memory land on registers this block does not
    // own, so such indirect accesses read zero and drop writes.
    assign sel_in_ram = (sel_addr >= `CSR_RAM_BASE) && (sel_addr <= `CSR_RAM_TOP);
    assign ind_hit = (reg_idx == `CSR_IDX_IND0) || (reg_idx == `CSR_IDX_IND1);
    assign status_wr = bus_wr && (reg_idx == `CSR_IDX_STATUS);

    assign alu_zero = (alu_result_i == 8'h00);
    assign alu_carry = alu_is_sub_i ? ~alu_carry_i : alu_carry_i;
    assign alu_digit_carry = alu_is_sub_i ? ~alu_digit_carry_i : alu_digit_carry_i;

    assign irq_event[`CSR_IRQ_TIMER] = timer_event_i;
    assign irq_event[`CSR_IRQ_TWOWIRE] = twowire_event_i;
    assign irq_event[`CSR_IRQ_CONVERTER] = converter_event_i;
    assign irq_event[`CSR_IRQ_PIN1] = port_b_line_1_event_i;
    assign irq_event[`CSR_IRQ_PIN0] = port_b_line_0_event_i;

    assign status_byte = {pointer1_page_select,
                          pointer0_page_select,
                          1'b0,
                          power_down_flag,
                          watchdog_timeout_flag,
                          digit_carry_flag,
                          carry_flag,
                          zero_flag};
    assign pending_byte = {3'b000, irq_pending};

    // The request is a plain combination of stored state so the core sees
    // a new enable or flag without an extra cycle of latency.
    assign irq_request_o = interrupt_enable_mask[`CSR_IE_GATE]
                           & (|(irq_pending & interrupt_enable_mask[`CSR_IRQ_SRCS-1:0]));

    // Wishbone acknowledge.
    always @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
        end
    end

    // Read data is captured when the request is first seen; unmapped
    // indices answer with zero.
    always @* begin
        rd_byte = 8'h00;
        case (reg_idx)
            `CSR_IDX_IND0, `CSR_IDX_IND1: begin
                if (sel_in_ram) begin
                    rd_byte = data_mem[sel_offset[7:0]];
                end
            end
            `CSR_IDX_PTR0: begin
                rd_byte = indirect_pointer0;
            end
            `CSR_IDX_PTR1: begin
                rd_byte = indirect_pointer1;
            end
            `CSR_IDX_STATUS: begin
                rd_byte = status_byte;
            end
            `CSR_IDX_INTERRUPT_PENDING_FLAGS: begin
                rd_byte = pending_byte;
            end
            `CSR_IDX_INTERRUPT_ENABLE_MASK: begin
                rd_byte = interrupt_enable_mask;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    always @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (bus_rd_start) begin
            wb_dat_o <= {24'h000000, rd_byte};
        end
    end

    // The indirect ports have no storage; writes go straight to memory.
    always @(posedge ref_clk_i) begin
        if (bus_wr && ind_hit && sel_in_ram) begin
            data_mem[sel_offset[7:0]] <= wr_byte;
        end
    end

    // Indirect pointers.
    always @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            indirect_pointer0 <= `CSR_RESET_BYTE;
            indirect_pointer1 <= `CSR_RESET_BYTE;
        end else if (bus_wr) begin
            if (reg_idx == `CSR_IDX_PTR0) begin
                indirect_pointer0 <= wr_byte;
            end
            if (reg_idx == `CSR_IDX_PTR1) begin
                indirect_pointer1 <= wr_byte;
            end
        end
    end

    // Page select bits.
    always @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            pointer1_page_select <= 1'b0;
            pointer0_page_select <= 1'b0;
        end else if (status_wr) begin
            pointer1_page_select <= wr_byte[`CSR_ST_PAGE1];
            pointer0_page_select <= wr_byte[`CSR_ST_PAGE0];
        end
    end

    // Power-down flag: only sleep sets it and only reset clears it.
    always @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            power_down_flag <= 1'b0;
        end else if (sleep_exec_i) begin
            power_down_flag <= 1'b1;
        end
    end

    // Timeout flag: software may clear it by writing zero, but writing one
    // does nothing, and a timeout in the same cycle wins over the clear.
    always @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            watchdog_timeout_flag <= 1'b0;
        end else if (wdt_timeout_i) begin
            watchdog_timeout_flag <= 1'b1;
        end else if (status_wr && !wr_byte[`CSR_ST_TO]) begin
            watchdog_timeout_flag <= 1'b0;
        end
    end

    // Arithmetic flags: an instruction that updates them keeps the ALU
    // values even when the same instruction writes the status register.
    always @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            digit_carry_flag <= 1'b0;
            carry_flag <= 1'b0;
            zero_flag <= 1'b0;
        end else if (alu_flag_upd_i) begin
            digit_carry_flag <= alu_digit_carry;
            carry_flag <= alu_carry;
            zero_flag <= alu_zero;
        end else if (status_wr) begin
            digit_carry_flag <= wr_byte[`CSR_ST_DC];
            carry_flag <= wr_byte[`CSR_ST_C];
            zero_flag <= wr_byte[`CSR_ST_Z];
        end
    end

    // Interrupt enables; bits 6:5 are not stored.
    always @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            interrupt_enable_mask <= `CSR_RESET_BYTE;
        end else if (bus_wr && (reg_idx == `CSR_IDX_INTERRUPT_ENABLE_MASK)) begin
            interrupt_enable_mask <= wr_byte & `CSR_INTERRUPT_ENABLE_MASK_MASK;
        end
    end

    // Pending flags, one per source. An event in the cycle of a software
    // write wins, so no event is lost to a clear.
    genvar gi;
    generate
        for (gi = 0; gi < `CSR_IRQ_SRCS; gi = gi + 1) begin : g_pending
            always @(posedge ref_clk_i) begin
                if (!rst_b_i) begin
                    irq_pending[gi] <= 1'b0;
                end else if (irq_event[gi]) begin
                    irq_pending[gi] <= 1'b1;
                end else if (bus_wr && (reg_idx == `CSR_IDX_INTERRUPT_PENDING_FLAGS)) begin
                    irq_pending[gi] <= wr_byte[gi];
                end
            end
        end
    endgenerate

    // Interrupt acceptance loads the shared vector. The pending flags are
    // left alone, so the handler must clear the one it serves.
    always @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            pc_load_o <= 1'b0;
            pc_load_addr_o <= 12'h000;
        end else begin
            pc_load_o <= irq_take_i & irq_request_o;
            pc_load_addr_o <= `CSR_IRQ_VECTOR;
        end
    end

    // Status mirror for the core.
    always @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            status_o <= `CSR_RESET_BYTE;
        end else begin
            status_o <= status_byte;
        end
    end

endmodule

// *** csr_defs.vh ***
`ifndef CSR_DEFS_VH
`define CSR_DEFS_VH

// Register indices; the byte address on the bus is four times the index.
`define CSR_IDX_W 3
`define CSR_IDX_IND0 3'h0
`define CSR_IDX_IND1 3'h1
`define CSR_IDX_PTR0 3'h2
`define CSR_IDX_PTR1 3'h3
`define CSR_IDX_STATUS 3'h4
`define CSR_IDX_INTERRUPT_PENDING_FLAGS 3'h6
`define CSR_IDX_INTERRUPT_ENABLE_MASK 3'h7

// Status register bit positions.
`define CSR_ST_PAGE1 7
`define CSR_ST_PAGE0 6
`define CSR_ST_PD 4
`define CSR_ST_TO 3
`define CSR_ST_DC 2
`define CSR_ST_C 1
`define CSR_ST_Z 0

// Interrupt register bit positions.
`define CSR_IE_GATE 7
`define CSR_IRQ_SRCS 5
`define CSR_IRQ_TIMER 4
`define CSR_IRQ_TWOWIRE 3
`define CSR_IRQ_CONVERTER 2
`define CSR_IRQ_PIN1 1
`define CSR_IRQ_PIN0 0

// Implemented-bit masks and reset values.
`define CSR_INTERRUPT_ENABLE_MASK_MASK 8'h9F
`define CSR_INTERRUPT_PENDING_FLAGS_MASK 8'h1F
`define CSR_RESET_BYTE 8'h00

// General data memory window reached through the indirect pointers.
`define CSR_RAM_BASE 9'h080
`define CSR_RAM_TOP 9'h17F
`define CSR_RAM_DEPTH 256

// Shared interrupt vector.
`define CSR_IRQ_VECTOR 12'h004

`endif

// *** csr_regs_properties.sv ***
`timescale 1ns/1ps
module csr_regs_properties (
    input wire ref_clk_i,
    input wire rst_b_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire wb_ack_o,
    input wire alu_flag_upd_i,
    input wire alu_is_sub_i,
    input wire [7:0] alu_result_i,
    input wire alu_carry_i,
    input wire alu_digit_carry_i,
    input wire sleep_exec_i,
    input wire irq_take_i,
    input wire irq_request_o,
    input wire pc_load_o,
    input wire [11:0] pc_load_addr_o,
    input wire [7:0] status_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    chk_ack_one_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one pulse");
    chk_zero_flag: assert property (alu_flag_upd_i |-> ##2 status_o[0] == ($past(alu_result_i, 2) == 8'h00))
        else $error("zero flag wrong");
    chk_carry_flag: assert property (alu_flag_upd_i |-> ##2 status_o[1] == ($past(alu_carry_i, 2) ^ $past(alu_is_sub_i, 2)))
        else $error("carry flag wrong");
    chk_digit_flag: assert property (alu_flag_upd_i |-> ##2 status_o[2] == ($past(alu_digit_carry_i, 2) ^ $past(alu_is_sub_i, 2)))
        else $error("digit carry flag wrong");
    chk_sleep_sets: assert property (sleep_exec_i |-> ##2 status_o[4])
        else $error("power-down flag not set");
    chk_sleep_sticky: assert property (status_o[4] |=> status_o[4])
        else $error("power-down flag lost");
    chk_vector_load: assert property (irq_take_i && irq_request_o |=> pc_load_o && pc_load_addr_o == 12'h004)
        else $error("vector not loaded");
    chk_request_held: assert property ($fell(irq_request_o) |-> $past(wb_ack_o && wb_we_i))
        else $error("request dropped without a write");
endmodule
bind csr_regs csr_regs_properties csr_regs_properties_inst (.ref_clk_i, .rst_b_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_ack_o, .alu_flag_upd_i, .alu_is_sub_i, .alu_result_i, .alu_carry_i,
    .alu_digit_carry_i, .sleep_exec_i, .irq_take_i, .irq_request_o, .pc_load_o, .pc_load_addr_o,
    .status_o);

// *** csr_core_model.sv ***
`timescale 1ns/1ps
module csr_core_model (
    input wire ref_clk_i,
    input wire rst_b_i,
    input wire irq_request_i,
    input wire [3:0] delay_i,
    output reg irq_take_o
);
    reg [3:0] wait_cnt;
    reg taken;
    // One acceptance per request; the service routine clears the flag, never the core.
    always @(posedge ref_clk_i) begin
        irq_take_o <= 1'b0;
        if (!rst_b_i || !irq_request_i) begin
            wait_cnt <= 4'h0;
            taken <= 1'b0;
        end else if (!taken && wait_cnt >= delay_i) begin
            irq_take_o <= 1'b1;
            taken <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

// *** csr_regs_test.sv ***
`timescale 1ns/1ps
module csr_regs_test;
    reg ref_clk_i, rst_b_i, wb_cyc_i, wb_stb_i, wb_we_i, alu_flag_upd_i, alu_is_sub_i;
    reg alu_carry_i, alu_digit_carry_i, sleep_exec_i, wdt_timeout_i;
    reg [4:0] wb_adr_i, ev;
    reg [3:0] wb_sel_i, dly;
    reg [31:0] wb_dat_i;
    reg [7:0] alu_result_i, q, d, ptr, e;
    reg [1:0] pgs;
    wire [31:0] wb_dat_o;
    wire [11:0] pc_load_addr_o;
    wire [7:0] status_o;
    wire wb_ack_o, irq_request_o, pc_load_o, irq_take_i;
    integer num_errors, checks, seed, i, n;
    csr_regs csr_regs_inst (.ref_clk_i, .rst_b_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .alu_flag_upd_i, .alu_is_sub_i,
        .alu_result_i, .alu_carry_i, .alu_digit_carry_i, .sleep_exec_i, .wdt_timeout_i,
        .irq_take_i, .timer_event_i(ev[4]), .twowire_event_i(ev[3]), .converter_event_i(ev[2]),
        .port_b_line_1_event_i(ev[1]), .port_b_line_0_event_i(ev[0]), .irq_request_o,
        .pc_load_o, .pc_load_addr_o, .status_o);
    csr_core_model csr_core_model_inst (.ref_clk_i, .rst_b_i, .irq_request_i(irq_request_o),
        .delay_i(dly), .irq_take_o(irq_take_i));
    function [7:0] flags_of(input [7:0] r, input c, input dc, input s);
        flags_of = {5'h00, dc ^ s, c ^ s, r == 8'h00};
    endfunction
    function [7:0] ind_of(input pg, input [7:0] p, input [7:0] v);
        ind_of = ({pg, p} >= 9'h080 && {pg, p} <= 9'h17F) ? v : 8'h00;
    endfunction
    task check8(input [7:0] got, input [7:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task bus(input [2:0] idx, input w, input [7:0] dv);
        begin
            @(posedge ref_clk_i);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= w;
            wb_adr_i <= {idx, 2'b00};
            wb_dat_i <= {24'h000000, dv};
            n = 0;
            @(posedge ref_clk_i);
            while (wb_ack_o !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge ref_clk_i);
            end
            if (n == 20) check8(8'h00, 8'h01);
            q = wb_dat_o[7:0];
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
        end
    endtask
    task finish_test;
        begin
            $display("errors %0d checks %0d", num_errors, checks);
            if (num_errors == 0 && checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        #2000000;
        num_errors = num_errors + 1;
        finish_test;
    end
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, alu_flag_upd_i, alu_is_sub_i, alu_carry_i} = 6'h00;
        {alu_digit_carry_i, sleep_exec_i, wdt_timeout_i, rst_b_i} = 4'h0;
        {wb_adr_i, ev, dly, wb_dat_i, alu_result_i} = 54'h0;
        wb_sel_i = 4'hF;
        num_errors = 0;
        checks = 0;
        seed = 32'h818C12B2;
        repeat (2) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        for (i = 4; i < 8; i = i + 1) begin
            bus(i[2:0], 1'b0, 8'h00);
            check8(q, 8'h00);
        end
        bus(3'h7, 1'b1, 8'hFF);
        bus(3'h7, 1'b0, 8'h00);
        check8(q, 8'h9F);
        bus(3'h6, 1'b1, 8'hFF);
        bus(3'h6, 1'b0, 8'h00);
        check8(q, 8'h1F);
        bus(3'h6, 1'b1, 8'h00);
        bus(3'h7, 1'b1, 8'h00);
        for (i = 0; i < 24; i = i + 1) begin
            pgs = $random(seed);
            ptr = $random(seed);
            d = $random(seed);
            if (i < 4) ptr = 8'h7F + i[1];
            bus(3'h4, 1'b1, {pgs, 6'h00});
            bus({2'b01, i[0]}, 1'b1, ptr);
            bus({2'b00, i[0]}, 1'b1, d);
            bus({2'b00, i[0]}, 1'b0, 8'h00);
            check8(q, ind_of(pgs[i[0]], ptr, d));
        end
        for (i = 0; i < 16; i = i + 1) begin
            d = $random(seed);
            if (i < 2) d = 8'h00;
            e = flags_of(d, i[1], i[2], i[0]);
            @(posedge ref_clk_i);
            alu_flag_upd_i <= 1'b1;
            alu_result_i <= d;
            alu_carry_i <= i[1];
            alu_digit_carry_i <= i[2];
            alu_is_sub_i <= i[0];
            if (i[3]) bus(3'h4, 1'b1, ~e); else @(posedge ref_clk_i);
            alu_flag_upd_i <= 1'b0;
            bus(3'h4, 1'b0, 8'h00);
            check8(q & 8'h07, e);
        end
        @(posedge ref_clk_i);
        sleep_exec_i <= 1'b1;
        wdt_timeout_i <= 1'b1;
        @(posedge ref_clk_i);
        sleep_exec_i <= 1'b0;
        wdt_timeout_i <= 1'b0;
        bus(3'h4, 1'b0, 8'h00);
        check8(q & 8'h18, 8'h18);
        bus(3'h4, 1'b1, 8'h00);
        bus(3'h4, 1'b0, 8'h00);
        check8(q & 8'h18, 8'h10);
        for (i = 0; i < 5; i = i + 1) begin
            dly <= i[3:0] * 4'h3;
            bus(3'h7, 1'b1, 8'h80 | (8'h01 << i));
            @(posedge ref_clk_i);
            ev <= 5'h01 << i;
            @(posedge ref_clk_i);
            ev <= 5'h00;
            // The flag is set at this edge, so look once it has settled.
            @(negedge ref_clk_i);
            check8({7'h00, irq_request_o}, 8'h01);
            n = 0;
            while (pc_load_o !== 1'b1 && n < 30) begin
                n = n + 1;
                @(posedge ref_clk_i);
            end
            check8({7'h00, pc_load_o}, 8'h01);
            bus(3'h6, 1'b0, 8'h00);
            check8(q, 8'h01 << i);
            bus(3'h7, 1'b1, 8'h01 << i);
            @(negedge ref_clk_i);
            check8({7'h00, irq_request_o}, 8'h00);
            bus(3'h7, 1'b1, 8'h80 | (8'h01 << i));
            @(negedge ref_clk_i);
            check8({7'h00, irq_request_o}, 8'h01);
            bus(3'h6, 1'b1, 8'h00);
            @(negedge ref_clk_i);
            check8({7'h00, irq_request_o}, 8'h00);
        end
        rst_b_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        bus(3'h4, 1'b0, 8'h00);
        check8(q, 8'h00);
        finish_test;
    end
endmodule
